/* rtl/ots_pkg.sv */
`default_nettype none

package ots_pkg;
    // Register location and field layout
    localparam logic [7:0] REG_ADDR_CONTROL     = 8'h29;
    localparam int         BIT_MONITOR_ENABLE   = 0;
    localparam int         BIT_OVERHEAT_FLAG    = 1;
    localparam int         BIT_FLAG_CLEAR       = 2;
    localparam logic       RST_MONITOR_ENABLE   = 1'h1;
    localparam logic       RST_OVERHEAT_FLAG    = 1'h0;
    // Thresholds in degrees Celsius
    localparam int         OVERHEAT_RISE_THRESHOLD = 140;
    localparam int         OVERHEAT_HYSTERESIS     = 5;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ots_reg_req_t;
endpackage

`default_nettype wire

/* rtl/ots_overtemperature_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none

module ots_overtemperature_supervisor #(
    parameter int TEMP_W = 9
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_in,
    input  wire logic [TEMP_W-1:0]     temp_c_in,
    input  wire ots_pkg::ots_reg_req_t reg_req_in,
    output logic [7:0]                 reg_rdata_out,
    output logic                       outputs_disable_out,
    output logic                       overheat_flag_out,
    output logic                       overheat_monitor_enable_out
);

    // Refuse widths that cannot hold the rise threshold
    if (TEMP_W < 8 || (2 ** TEMP_W) <= ots_pkg::OVERHEAT_RISE_THRESHOLD)
    begin : g_width_check
        $error("TEMP_W too narrow for the threshold");
    end

    // Release point sits one hysteresis step below the rise point
    localparam logic [TEMP_W-1:0] RISE = TEMP_W'(ots_pkg::OVERHEAT_RISE_THRESHOLD);
    localparam logic [TEMP_W-1:0] FALL =
        TEMP_W'(ots_pkg::OVERHEAT_RISE_THRESHOLD - ots_pkg::OVERHEAT_HYSTERESIS);

    ////////////////////////////////////////////////////////////////////////////
    logic reg_hit;
    logic clear_req;
    logic hot;
    logic cool;
    logic flag_clear;

    // Sensor value arrives in whole degrees, so plain compares suffice
    // Bits of the register outside this block are decoded elsewhere
    assign reg_hit   = reg_req_in.addr == ots_pkg::REG_ADDR_CONTROL;
    assign clear_req = reg_hit && reg_req_in.wr && reg_req_in.wdata[ots_pkg::BIT_FLAG_CLEAR];
    assign hot       = temp_c_in >= RISE;
    assign cool      = temp_c_in < FALL;

    ////////////////////////////////////////////////////////////////////////////
    // Enable bit
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            overheat_monitor_enable_out <= ots_pkg::RST_MONITOR_ENABLE;
        else if (reg_hit && reg_req_in.wr)
            overheat_monitor_enable_out <= reg_req_in.wdata[ots_pkg::BIT_MONITOR_ENABLE];
    end

    // Clear strobe is a one-cycle pulse, so the bit never stays at one
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            flag_clear <= 1'b0;
        else
            flag_clear <= clear_req;
    end

    // Sticky flag; a new overheat in the clearing cycle wins
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            overheat_flag_out <= ots_pkg::RST_OVERHEAT_FLAG;
        else if (overheat_monitor_enable_out && hot)
            overheat_flag_out <= 1'b1;
        else if (flag_clear)
            overheat_flag_out <= 1'b0;
    end

    // Shutdown with hysteresis; held between FALL and RISE to avoid chatter
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            outputs_disable_out <= 1'b0;
        else if (!overheat_monitor_enable_out)
            outputs_disable_out <= 1'b0;
        else if (hot)
            outputs_disable_out <= 1'b1;
        else if (cool)
            outputs_disable_out <= 1'b0;
    end

    // Read data; clear bit reads zero, other bits of the register are elsewhere
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            reg_rdata_out <= 8'h00;
        else if (reg_hit && reg_req_in.rd)
        begin
            reg_rdata_out <= 8'h00;
            reg_rdata_out[ots_pkg::BIT_OVERHEAT_FLAG]  <= overheat_flag_out;
            reg_rdata_out[ots_pkg::BIT_MONITOR_ENABLE] <= overheat_monitor_enable_out;
        end
        else
            reg_rdata_out <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_rise_sets_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        overheat_monitor_enable_out && hot |=> overheat_flag_out && outputs_disable_out)
        else $error("overheat did not set flag and shutdown");

    a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        overheat_flag_out && !flag_clear |=> overheat_flag_out)
        else $error("flag dropped without clear");

    a_clear_works: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        clear_req && !hot ##1 !hot |=> !overheat_flag_out)
        else $error("clear write ignored");

    a_clear_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        flag_clear && !clear_req |=> !flag_clear)
        else $error("clear bit not self clearing");

    a_hold_hyst: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        outputs_disable_out && overheat_monitor_enable_out && !cool |=> outputs_disable_out)
        else $error("released before hysteresis");

    a_release_cool: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        cool |=> !outputs_disable_out)
        else $error("not released when cool");

    a_disabled_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !overheat_monitor_enable_out && !overheat_flag_out |=> !outputs_disable_out && !overheat_flag_out)
        else $error("acted while disabled");

    a_read_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_hit && reg_req_in.rd |=> reg_rdata_out[1] == $past(overheat_flag_out))
        else $error("read data flag mismatch");

    a_enable_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_hit && reg_req_in.wr |=> overheat_monitor_enable_out == $past(reg_req_in.wdata[0]))
        else $error("enable write lost");

    ////////////////////////////////////////////////////////////////////////////
    // Threshold, shutdown and reset values
    a_reset_values: assert property (@(posedge clk_sys_in)
        rst_in |=> !overheat_flag_out && overheat_monitor_enable_out && !outputs_disable_out && reg_rdata_out == 8'h00)
        else $error("reset values wrong");

    a_below_rise: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        overheat_monitor_enable_out && !hot && !overheat_flag_out |=> !overheat_flag_out)
        else $error("flag set below threshold");

    a_no_early_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !outputs_disable_out && !hot |=> !outputs_disable_out)
        else $error("shutdown below threshold");

    a_hot_holds_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        outputs_disable_out && overheat_monitor_enable_out && hot |=> outputs_disable_out)
        else $error("shutdown dropped while hot");

    a_flag_on_resume: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        overheat_flag_out && cool && !flag_clear |=> overheat_flag_out && !outputs_disable_out)
        else $error("flag lost on resume");

    a_disabled_free: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !overheat_monitor_enable_out |=> !outputs_disable_out)
        else $error("shutdown while disabled");

    a_disabled_no_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !overheat_monitor_enable_out |=> !$rose(overheat_flag_out))
        else $error("flag set while disabled");

    ////////////////////////////////////////////////////////////////////////////
    // Clearing; a pending overheat must always beat the clear
    a_clear_loses: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        flag_clear && overheat_monitor_enable_out && hot |=> overheat_flag_out)
        else $error("clear beat overheat");

    a_clear_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $fell(overheat_flag_out) |-> $past(flag_clear))
        else $error("flag fell without clear");

    a_clear_strobe: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        clear_req |=> flag_clear)
        else $error("clear strobe missing");

    a_clear_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !clear_req |=> !flag_clear)
        else $error("clear strobe without write");

    a_read_keeps: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_hit && reg_req_in.rd && overheat_flag_out && !flag_clear |=> overheat_flag_out)
        else $error("read cleared flag");

    ////////////////////////////////////////////////////////////////////////////
    // Register view
    a_read_enable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_hit && reg_req_in.rd |=> reg_rdata_out[ots_pkg::BIT_MONITOR_ENABLE] == $past(overheat_monitor_enable_out))
        else $error("read data enable mismatch");

    a_read_clear_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        reg_hit && reg_req_in.rd |=> reg_rdata_out[ots_pkg::BIT_FLAG_CLEAR] == 1'b0)
        else $error("clear bit read back as one");

    a_other_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !reg_hit |=> reg_rdata_out == 8'h00 && $stable(overheat_monitor_enable_out))
        else $error("other address acted");

    a_rdata_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(reg_hit && reg_req_in.rd) |=> reg_rdata_out == 8'h00)
        else $error("read data outside read");

endmodule

`default_nettype wire

/* bench/ots_overtemperature_supervisor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ots_overtemperature_supervisor_tb_top;
    logic                  clk_sys_in = 1'h0;
    logic                  rst_in     = 1'h1;
    logic [8:0]            temp_c_in  = 9'h019;
    ots_pkg::ots_reg_req_t req        = '0;
    logic [7:0]            rdata;
    logic                  dis;
    logic                  flag;
    logic                  en;
    int                    failures   = 0;
    int                    tests_run  = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    ots_overtemperature_supervisor u_ots_overtemperature_supervisor (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .temp_c_in(temp_c_in), .reg_req_in(req), .reg_rdata_out(rdata), .outputs_disable_out(dis),
        .overheat_flag_out(flag), .overheat_monitor_enable_out(en));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] st();
        return {5'h00, dis, flag, en};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle strobe; registered read data is sampled at the negedge that ends it
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req = '{wr: w, rd: ~w, addr: a, wdata: d};
        @(negedge clk_sys_in);
        req = '0;
    endtask
    task automatic results;
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(st(), 8'h01);
        acc(1'h0, 8'h29, 8'h00);
        chk(rdata, 8'h01);
        acc(1'h0, 8'h28, 8'h00);
        chk(rdata, 8'h00);
    endtask
    task automatic t_overheat;
        temp_c_in = 9'h08b;
        repeat (3) @(negedge clk_sys_in);
        chk(st(), 8'h01);
        temp_c_in = 9'h08c;
        @(negedge clk_sys_in);
        chk(st(), 8'h07);
        temp_c_in = 9'h087;
        repeat (3) @(negedge clk_sys_in);
        chk(st(), 8'h07);
        temp_c_in = 9'h086;
        @(negedge clk_sys_in);
        chk(st(), 8'h03);
        acc(1'h0, 8'h29, 8'h00);
        chk(rdata, 8'h03);
        acc(1'h0, 8'h29, 8'h00);
        chk(rdata, 8'h03);
    endtask
    task automatic t_clear;
        acc(1'h1, 8'h28, 8'h04);
        repeat (2) @(negedge clk_sys_in);
        chk(st(), 8'h03);
        acc(1'h1, 8'h29, 8'h05);
        repeat (2) @(negedge clk_sys_in);
        chk(st(), 8'h01);
        // A clear bit that stuck at one would drop the new flag
        temp_c_in = 9'h08c;
        repeat (2) @(negedge clk_sys_in);
        acc(1'h1, 8'h29, 8'h05);
        repeat (2) @(negedge clk_sys_in);
        chk(st(), 8'h07);
        temp_c_in = 9'h086;
        repeat (2) @(negedge clk_sys_in);
        chk(st(), 8'h03);
    endtask
    task automatic t_disabled;
        acc(1'h1, 8'h29, 8'h04);
        temp_c_in = 9'h096;
        repeat (3) @(negedge clk_sys_in);
        chk(st(), 8'h00);
        acc(1'h0, 8'h29, 8'h00);
        chk(rdata, 8'h00);
        acc(1'h1, 8'h29, 8'h01);
        repeat (2) @(negedge clk_sys_in);
        chk(st(), 8'h07);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'h0;
        t_reset();
        t_overheat();
        t_clear();
        t_disabled();
        results();
    end
    initial
    begin
        #100000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
